// ===== bench/bit_carry_far_model.sv
// far-side model: register file and byte memory for the bit unit
// assumes: shares the unit clock; memory answers 1 to 4 cycles after a read
`timescale 1ns/100ps
module bit_carry_far_model
   import bit_carry_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic [REG_W-1:0] rf_rd_a_sel_o, rf_rd_b_sel_o, rf_wr_sel_o,
   input wire logic rf_wr_en_o, mem_rd_o, mem_wr_o,
   input wire logic [DATA_W-1:0] rf_wr_data_o, mem_wr_data_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] rf_rd_a_data_i, rf_rd_b_data_i, mem_rd_data_i,
   output logic mem_rd_valid_i
);
   // ----
   // storage and reply timing
   // ----
   logic [DATA_W-1:0] rf [8];
   logic [DATA_W-1:0] mem [256];
   int cnt = 0;
   assign rf_rd_a_data_i = rf[rf_rd_a_sel_o];
   assign rf_rd_b_data_i = rf[rf_rd_b_sel_o];
   initial {mem_rd_valid_i, mem_rd_data_i} = 9'h000;
   // data toggles outside a reply so a stale byte never looks valid
   always @(posedge clk_sys_i) begin
      mem_rd_valid_i <= 1'b0;
      mem_rd_data_i <= ~mem_rd_data_i;
      if (rf_wr_en_o) rf[rf_wr_sel_o] <= rf_wr_data_o;
      if (mem_wr_o) mem[mem_addr_o] <= mem_wr_data_o;
      if (mem_rd_o) cnt <= $urandom_range(1, 4);
      else if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1 && !mem_rd_o) begin
         mem_rd_valid_i <= 1'b1;
         mem_rd_data_i <= mem[mem_addr_o];
      end
   end
endmodule

// ===== bench/bit_carry_logic_unit_sva.sv
// assertion checker for the bit unit, bound onto its ports
// assumes: one clock, synchronous active-low reset
`timescale 1ns/100ps
module bit_carry_logic_unit_sva
   import bit_carry_pkg::*;
(
   input wire logic clk_sys_i, rst_n_i, start_i, carry_i, mem_rd_valid_i,
   input wire logic [OP_W-1:0] op_i,
   input wire logic [MODE_W-1:0] mode_i,
   input wire logic [SRC_W-1:0] idx_src_i,
   input wire logic [IDX_W-1:0] imm_idx_i,
   input wire logic [ADDR_W-1:0] abs_addr_i, mem_addr_o,
   input wire logic [DATA_W-1:0] rf_rd_a_data_i, mem_rd_data_i, rf_wr_data_o, mem_wr_data_o,
   input wire logic busy_o, done_o, illegal_o, carry_o, carry_wr_o, rf_wr_en_o, mem_rd_o, mem_wr_o
);
   // ----
   // request decode and properties
   // ----
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire go = start_i && !busy_o;
   wire bad = op_i > 4'hD || mode_i == 2'h3 || (idx_src_i == 1'b1 && op_i < 4'hA);
   wire ok = go && !bad;
   wire reg_ok = ok && mode_i == 2'h0;
   sequence s_reg_done; busy_o ##1 done_o; endsequence
   sequence s_rmw; mem_rd_valid_i && busy_o ##2 mem_wr_o; endsequence
   illegal_pulse_a: assert property (go && bad |=> illegal_o && done_o && !mem_rd_o && !carry_wr_o)
      else $error("bad request not refused");
   reg_timing_a: assert property (reg_ok |=> s_reg_done)
      else $error("register request timing");
   mem_read_a: assert property (ok && mode_i != 2'h0 |=> mem_rd_o ##1 !mem_rd_o)
      else $error("memory read missing");
   abs_addr_a: assert property (ok && mode_i == 2'h2 |=> mem_addr_o == $past(abs_addr_i))
      else $error("absolute address wrong");
   load_carry_a: assert property (reg_ok && op_i == 4'h2 |-> ##2 carry_wr_o &&
      carry_o == $past(rf_rd_a_data_i[imm_idx_i], 2))
      else $error("load carry wrong");
   xor_carry_a: assert property (reg_ok && op_i == 4'h0 |-> ##2
      carry_o == $past(carry_i ^ rf_rd_a_data_i[imm_idx_i], 2))
      else $error("xor carry wrong");
   reg_store_a: assert property (reg_ok && op_i == 4'h4 |-> ##2 rf_wr_en_o &&
      rf_wr_data_o[$past(imm_idx_i, 2)] == $past(carry_i, 2))
      else $error("store bit wrong");
   one_bit_a: assert property (s_rmw |-> $countones(mem_wr_data_o ^ $past(mem_rd_data_i, 2)) <= 1)
      else $error("memory byte altered");
endmodule
bind bit_carry_logic_unit bit_carry_logic_unit_sva u_sva(.clk_sys_i, .rst_n_i, .start_i, .carry_i, .mem_rd_valid_i,
   .op_i, .mode_i, .idx_src_i, .imm_idx_i, .abs_addr_i, .mem_addr_o, .rf_rd_a_data_i, .mem_rd_data_i, .rf_wr_data_o,
   .mem_wr_data_o, .busy_o, .done_o, .illegal_o, .carry_o, .carry_wr_o, .rf_wr_en_o, .mem_rd_o, .mem_wr_o);

// ===== bench/tb_bit_carry_logic_unit.sv
// bench: random bit requests checked against a reference model
// assumes: far-side model arrays are reached by hierarchy for setup and checks
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s %h %h", nm, e, g); end end
module tb_bit_carry_logic_unit
   import bit_carry_pkg::*;
;
   // ----
   // signals, units and reference state
   // ----
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, carry_i = 1'b0, zero_i = 1'b0, cy = 1'b0;
   logic [SRC_W-1:0] idx_src_i = 1'b0;
   logic [OP_W-1:0] op_i = 4'h0;
   logic [MODE_W-1:0] mode_i = 2'h0;
   logic [2:0] imm_idx_i = 3'h0, operand_register_field_i = 3'h0, bit_index_register_field_i = 3'h0;
   logic [7:0] abs_addr_i = 8'h00;
   logic [2:0] rf_rd_a_sel_o, rf_rd_b_sel_o, rf_wr_sel_o;
   logic [7:0] rf_rd_a_data_i, rf_rd_b_data_i, rf_wr_data_o, mem_addr_o, mem_wr_data_o, mem_rd_data_i;
   logic rf_wr_en_o, mem_rd_o, mem_wr_o, mem_rd_valid_i, carry_o, carry_wr_o, zero_o, zero_wr_o, illegal_o;
   logic busy_o, done_o;
   logic [7:0] rf_ref [8];
   logic [7:0] mem_ref [256];
   int num_errors = 0, n_compared = 0;
   bit_carry_logic_unit dut(.clk_sys_i, .rst_n_i, .start_i, .op_i, .mode_i, .idx_src_i, .imm_idx_i,
      .operand_register_field_i, .bit_index_register_field_i, .abs_addr_i, .carry_i, .zero_i, .rf_rd_a_sel_o,
      .rf_rd_a_data_i, .rf_rd_b_sel_o, .rf_rd_b_data_i, .rf_wr_en_o, .rf_wr_sel_o, .rf_wr_data_o, .mem_rd_o,
      .mem_wr_o, .mem_addr_o, .mem_wr_data_o, .mem_rd_valid_i, .mem_rd_data_i, .carry_o, .carry_wr_o, .zero_o,
      .zero_wr_o, .illegal_o, .busy_o, .done_o);
   bit_carry_far_model pm(.clk_sys_i, .rf_rd_a_sel_o, .rf_rd_b_sel_o, .rf_wr_sel_o, .rf_wr_en_o, .mem_rd_o,
      .mem_wr_o, .rf_wr_data_o, .mem_wr_data_o, .mem_addr_o, .rf_rd_a_data_i, .rf_rd_b_data_i, .mem_rd_data_i,
      .mem_rd_valid_i);
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic run_op(input logic [3:0] op);
      logic [1:0] m;
      logic s, cn, b, ill, cw, zw;
      logic [2:0] ix, im, rn, rm;
      logic [7:0] aa, a, v;
      int n;
      m = 2'($urandom_range(0, 3));
      s = 1'($urandom_range(0, 1));
      {im, rn, rm, aa} = 17'($urandom);
      ix = s ? rf_ref[rm][2:0] : im;
      a = m == 2'h1 ? rf_ref[rn] : aa;
      v = m == 2'h0 ? rf_ref[rn] : mem_ref[a];
      b = v[ix];
      ill = op > 4'hD || m == 2'h3 || (s && op < 4'hA);
      cn = cy;
      case (op)
         4'h0: cn = cy ^ b;
         4'h1: cn = cy ^ !b;
         4'h2: cn = b;
         4'h3: cn = !b;
         4'h4: v[ix] = cy;
         4'h5: v[ix] = !cy;
         4'h6: cn = cy & b;
         4'h7: cn = cy & !b;
         4'h8: cn = cy | b;
         4'h9: cn = cy | !b;
         4'hA: v[ix] = 1'b1;
         4'hB: v[ix] = 1'b0;
         4'hC: v[ix] = !b;
         default: cn = cy;
      endcase
      cw = !ill && (op < 4'h4 || (op > 4'h5 && op < 4'hA));
      zw = !ill && op == 4'hD;
      @(posedge clk_sys_i);
      {start_i, op_i, mode_i, idx_src_i, imm_idx_i} <= {1'b1, op, m, s, im};
      {operand_register_field_i, bit_index_register_field_i, abs_addr_i, carry_i} <= {rn, rm, aa, cy};
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      n = 0;
      #1;
      while (done_o !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      `CHK("done", 1'b1, done_o)
      `CHK("illegal", ill, illegal_o)
      `CHK("carry_wr", cw, carry_wr_o)
      if (cw) `CHK("carry", cn, carry_o)
      `CHK("zero_wr", zw, zero_wr_o)
      if (zw) `CHK("zero", !b, zero_o)
      if (cw) cy = cn;
      if (!ill && op inside {4'h4, 4'h5, 4'hA, 4'hB, 4'hC}) begin
         if (m == 2'h0) rf_ref[rn] = v;
         else mem_ref[a] = v;
      end
      @(posedge clk_sys_i);
      #1;
      for (int i = 0; i < 8; i++) `CHK("reg", rf_ref[i], pm.rf[i])
      for (int i = 0; i < 256; i++) `CHK("mem", mem_ref[i], pm.mem[i])
   endtask
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      void'($urandom(7));
      for (int i = 0; i < 256; i++) begin
         mem_ref[i] = 8'($urandom);
         pm.mem[i] = mem_ref[i];
      end
      for (int i = 0; i < 8; i++) begin
         rf_ref[i] = 8'($urandom);
         pm.rf[i] = rf_ref[i];
      end
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      // cycling the code keeps every operation, legal or not, in the mix
      for (int k = 0; k < 320; k++) run_op(4'(k % 16));
      report_and_stop();
   end
   // requests end within twenty cycles; this is several times the full run
   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end
endmodule

// ===== logic/bit_carry_logic_unit.sv
// bit_carry_logic_unit: carry-flag and single-bit execution for the bit instructions
// assumes: decoder presents one instruction per start pulse and holds it until done;
// register file read ports are combinational; memory answers a read with rd_valid
`timescale 1ns/100ps
module bit_carry_logic_unit
   import bit_carry_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // decoder side
   input wire logic start_i,
   input wire logic [OP_W-1:0] op_i,
   input wire logic [MODE_W-1:0] mode_i,
   input wire logic [SRC_W-1:0] idx_src_i,
   input wire logic [IDX_W-1:0] imm_idx_i,
   input wire logic [REG_W-1:0] operand_register_field_i,
   input wire logic [REG_W-1:0] bit_index_register_field_i,
   input wire logic [ADDR_W-1:0] abs_addr_i,
   input wire logic carry_i,
   input wire logic zero_i,
   // register file side
   output logic [REG_W-1:0] rf_rd_a_sel_o,
   input wire logic [DATA_W-1:0] rf_rd_a_data_i,
   output logic [REG_W-1:0] rf_rd_b_sel_o,
   input wire logic [DATA_W-1:0] rf_rd_b_data_i,
   output logic rf_wr_en_o,
   output logic [REG_W-1:0] rf_wr_sel_o,
   output logic [DATA_W-1:0] rf_wr_data_o,
   // memory side
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic [DATA_W-1:0] mem_wr_data_o,
   input wire logic mem_rd_valid_i,
   input wire logic [DATA_W-1:0] mem_rd_data_i,
   // results
   output logic carry_o,
   output logic carry_wr_o,
   output logic zero_o,
   output logic zero_wr_o,
   output logic illegal_o,
   output logic busy_o,
   output logic done_o
);
   // ---------------------------------------------------------------
   // operand decode
   // ---------------------------------------------------------------
   unit_state_e state;
   unit_state_e next_state;
   bit_op_e op_q;
   addr_mode_e mode_q;
   logic [IDX_W-1:0] idx_q;
   logic [REG_W-1:0] rn_q;
   logic [ADDR_W-1:0] addr_q;
   logic carry_q;
   logic [DATA_W-1:0] mem_byte_q;

   wire bit_op_e op_w = bit_op_e'(op_i);
   wire logic is_bit_change = (op_w == bit_set_op) || (op_w == bit_clear_op) || (op_w == bit_invert_op);
   wire logic is_bit_family = is_bit_change || (op_w == bit_test_op);
   // only the set/clear/invert/test group may take its index from a register
   wire logic reg_idx_ok = is_bit_family;
   wire logic idx_bad = (idx_src_i == idx_register) && !reg_idx_ok;
   wire logic op_bad = (op_i > 4'hD);
   wire logic mode_bad = (mode_i == 2'h3);
   // a refused request still answers with done, so the decoder never stalls
   wire logic start_bad = start_i && (state == st_idle) && (idx_bad || op_bad || mode_bad);
   wire logic start_ok = start_i && (state == st_idle) && !(idx_bad || op_bad || mode_bad);

   // register index keeps only the low three bits
   wire logic [IDX_W-1:0] reg_idx = rf_rd_b_data_i[IDX_W-1:0];
   wire logic [IDX_W-1:0] sel_idx = (idx_src_i == idx_register) ? reg_idx : imm_idx_i;
   // indirect pointer comes from the operand register
   // limitation: pointer and index are read at start, so a write landing that same edge is missed
   wire logic [ADDR_W-1:0] ind_addr = IND_BASE_ADDR | rf_rd_a_data_i;
   wire logic [ADDR_W-1:0] sel_addr = (mode_i == mode_absolute) ? abs_addr_i : ind_addr;

   assign rf_rd_a_sel_o = (state == st_idle) ? operand_register_field_i : rn_q;
   assign rf_rd_b_sel_o = bit_index_register_field_i;

   // ---------------------------------------------------------------
   // bit select and merge
   // ---------------------------------------------------------------
   // direct operands are read in the write state, after an earlier store has landed
   wire logic from_mem = (mode_q != mode_reg_direct);
   wire logic [DATA_W-1:0] src_byte = from_mem ? mem_byte_q : rf_rd_a_data_i;
   wire logic picked;
   logic new_bit;
   wire logic [DATA_W-1:0] merged;

   bit_select_mod u_sel (
      .byte_i(src_byte),
      .index_i(idx_q),
      .new_bit_i(new_bit),
      .picked_o(picked),
      .merged_o(merged)
   );

   // ---------------------------------------------------------------
   // carry, zero and new bit per operation
   // ---------------------------------------------------------------
   logic next_carry;
   logic carry_upd;
   logic bit_upd;
   logic zero_upd;

   always_comb begin
      next_carry = carry_q;
      carry_upd = 1'b0;
      bit_upd = 1'b0;
      zero_upd = 1'b0;
      new_bit = picked;
      case (op_q)
         carry_xor_bit: begin
            next_carry = carry_q ^ picked;
            carry_upd = 1'b1;
         end
         carry_xor_inv_bit: begin
            next_carry = carry_q ^ ~picked;
            carry_upd = 1'b1;
         end
         carry_load_bit: begin
            next_carry = picked;
            carry_upd = 1'b1;
         end
         carry_load_inv_bit: begin
            next_carry = ~picked;
            carry_upd = 1'b1;
         end
         carry_store_bit: begin
            new_bit = carry_q;
            bit_upd = 1'b1;
         end
         carry_store_inv_bit: begin
            new_bit = ~carry_q;
            bit_upd = 1'b1;
         end
         carry_and_bit: begin
            next_carry = carry_q & picked;
            carry_upd = 1'b1;
         end
         carry_and_inv_bit: begin
            next_carry = carry_q & ~picked;
            carry_upd = 1'b1;
         end
         carry_or_bit: begin
            next_carry = carry_q | picked;
            carry_upd = 1'b1;
         end
         carry_or_inv_bit: begin
            next_carry = carry_q | ~picked;
            carry_upd = 1'b1;
         end
         bit_set_op: begin
            new_bit = 1'b1;
            bit_upd = 1'b1;
         end
         bit_clear_op: begin
            new_bit = 1'b0;
            bit_upd = 1'b1;
         end
         bit_invert_op: begin
            new_bit = ~picked;
            bit_upd = 1'b1;
         end
         bit_test_op: begin
            zero_upd = 1'b1;
         end
         default: begin
            next_carry = carry_q;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // register operands finish in st_write; memory operands read first
   wire logic exec_now = (state == st_write);
   wire logic mem_write_now = exec_now && from_mem && bit_upd;

   always_comb begin
      next_state = state;
      case (state)
         st_idle: begin
            if (start_ok) begin
               next_state = (mode_i == mode_reg_direct) ? st_write : st_read;
            end
         end
         st_read: begin
            next_state = st_wait;
         end
         st_wait: begin
            if (mem_rd_valid_i) begin
               next_state = st_write;
            end
         end
         st_write: begin
            next_state = st_idle;
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state and request registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state <= st_idle;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         op_q <= carry_xor_bit;
         mode_q <= mode_reg_direct;
         idx_q <= 3'h0;
         rn_q <= 3'h0;
         addr_q <= 8'h00;
         carry_q <= 1'b0;
      end else if (start_ok) begin
         op_q <= op_w;
         mode_q <= addr_mode_e'(mode_i);
         idx_q <= sel_idx;
         rn_q <= operand_register_field_i;
         addr_q <= sel_addr;
         carry_q <= carry_i;
      end
   end

   // one capture per request; the write-back merges into this copy, never a second read
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mem_byte_q <= 8'h00;
      end else if (state == st_wait && mem_rd_valid_i) begin
         mem_byte_q <= mem_rd_data_i;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rf_wr_en_o <= 1'b0;
         rf_wr_sel_o <= 3'h0;
         rf_wr_data_o <= 8'h00;
         mem_wr_o <= 1'b0;
         mem_wr_data_o <= 8'h00;
      end else begin
         rf_wr_en_o <= exec_now && !from_mem && bit_upd;
         rf_wr_sel_o <= rn_q;
         rf_wr_data_o <= merged;
         mem_wr_o <= mem_write_now;
         mem_wr_data_o <= merged;
      end
   end

   // ---------------------------------------------------------------
   // flag and completion outputs
   // ---------------------------------------------------------------
   // flags load in every st_write and hold otherwise; the decoder reads them only on the write pulses
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         carry_o <= 1'b0;
         carry_wr_o <= 1'b0;
         zero_o <= 1'b0;
         zero_wr_o <= 1'b0;
         done_o <= 1'b0;
         illegal_o <= 1'b0;
      end else begin
         carry_o <= exec_now ? next_carry : carry_o;
         carry_wr_o <= exec_now && carry_upd;
         zero_o <= exec_now ? ~picked : zero_o;
         zero_wr_o <= exec_now && zero_upd;
         done_o <= exec_now || start_bad;
         illegal_o <= start_bad;
      end
   end

   assign mem_rd_o = (state == st_read);
   // held from start to the next start, so a slow far side may sample it late
   assign mem_addr_o = addr_q;
   assign busy_o = (state != st_idle);
endmodule

// ===== logic/bit_carry_pkg.sv
// bit_carry_pkg: operation codes, addressing forms, field widths and state codes
// assumes: shared by bit_carry_logic_unit and bit_select_mod
package bit_carry_pkg;
   localparam int DATA_W = 8;
   localparam int IDX_W = 3;
   localparam int REG_W = 3;
   localparam int ADDR_W = 8;
   localparam int OP_W = 4;
   localparam int MODE_W = 2;
   localparam int SRC_W = 1;
   localparam logic [7:0] IND_BASE_ADDR = 8'h00;

   typedef enum logic [3:0] {
      carry_xor_bit = 4'h0,
      carry_xor_inv_bit = 4'h1,
      carry_load_bit = 4'h2,
      carry_load_inv_bit = 4'h3,
      carry_store_bit = 4'h4,
      carry_store_inv_bit = 4'h5,
      carry_and_bit = 4'h6,
      carry_and_inv_bit = 4'h7,
      carry_or_bit = 4'h8,
      carry_or_inv_bit = 4'h9,
      bit_set_op = 4'hA,
      bit_clear_op = 4'hB,
      bit_invert_op = 4'hC,
      bit_test_op = 4'hD
   } bit_op_e;

   typedef enum logic [1:0] {
      mode_reg_direct = 2'h0,
      mode_reg_indirect = 2'h1,
      mode_absolute = 2'h2
   } addr_mode_e;

   typedef enum logic [0:0] {
      idx_immediate = 1'b0,
      idx_register = 1'b1
   } idx_src_e;

   // gray path: idle -> read -> wait -> write -> (back to idle)
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_read = 2'b01,
      st_wait = 2'b11,
      st_write = 2'b10
   } unit_state_e;
endpackage

// ===== logic/bit_select_mod.sv
// bit_select_mod: picks one bit of a byte and builds the byte with that bit replaced
// assumes: purely combinational, index already reduced to three bits
`timescale 1ns/100ps
module bit_select_mod
   import bit_carry_pkg::*;
(
   input wire logic [DATA_W-1:0] byte_i,
   input wire logic [IDX_W-1:0] index_i,
   input wire logic new_bit_i,
   output logic picked_o,
   output logic [DATA_W-1:0] merged_o
);
   wire logic [DATA_W-1:0] one_hot = 8'h01 << index_i;

   assign picked_o = byte_i[index_i];
   // only the selected bit changes, the rest pass through
   assign merged_o = (byte_i & ~one_hot) | (new_bit_i ? one_hot : 8'h00);
endmodule
